// >>> inc/etm_pkg.sv
// Package for the enhanced timer: register map, fields, modes and carriers
package etm_pkg;

  localparam int ETM_CW = 10;

  // Register byte addresses on the APB bus
  localparam logic [7:0] ETM_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ETM_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ETM_ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ETM_ADDR_CNTL = 8'h0C;
  localparam logic [7:0] ETM_ADDR_CNTH = 8'h10;
  localparam logic [7:0] ETM_ADDR_MAL = 8'h14;
  localparam logic [7:0] ETM_ADDR_MAH = 8'h18;
  localparam logic [7:0] ETM_ADDR_MBL = 8'h1C;
  localparam logic [7:0] ETM_ADDR_MBH = 8'h20;
  localparam logic [7:0] ETM_ADDR_FLAGS = 8'h24;

  localparam logic [7:0] ETM_CTRL_RST = 8'h00;
  localparam logic [9:0] ETM_CNT_MAX = 10'h3FF;
  localparam logic [9:0] ETM_CNT_ZERO = 10'h000;
  localparam logic [2:0] ETM_PER_FREE = 3'h0;

  // Channel modes
  localparam logic [1:0] ETM_MODE_CMP = 2'h0;
  localparam logic [1:0] ETM_MODE_CAP = 2'h1;
  localparam logic [1:0] ETM_MODE_PWM = 2'h2;
  localparam logic [1:0] ETM_MODE_TMR = 2'h3;

  // Pin function codes
  localparam logic [1:0] ETM_FN_0 = 2'h0;
  localparam logic [1:0] ETM_FN_1 = 2'h1;
  localparam logic [1:0] ETM_FN_2 = 2'h2;
  localparam logic [1:0] ETM_FN_3 = 2'h3;

  // Clock select codes
  localparam logic [2:0] ETM_CK_SYS4 = 3'h0;
  localparam logic [2:0] ETM_CK_SYS = 3'h1;
  localparam logic [2:0] ETM_CK_H16 = 3'h2;
  localparam logic [2:0] ETM_CK_H64 = 3'h3;
  localparam logic [2:0] ETM_CK_SUB0 = 3'h4;
  localparam logic [2:0] ETM_CK_SUB1 = 3'h5;
  localparam logic [2:0] ETM_CK_RISE = 3'h6;
  localparam logic [2:0] ETM_CK_FALL = 3'h7;

  localparam logic [1:0] ETM_PWM_EDGE = 2'h0;
  localparam logic [1:0] ETM_PWM_UP = 2'h1;
  localparam logic [1:0] ETM_PWM_DN = 2'h2;

  typedef struct packed {
    logic counter_hold;
    logic [2:0] count_clock_select;
    logic counter_on;
    logic [2:0] period_value;
  } etm_ctrl0_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pin_function;
    logic out_control;
    logic polarity;
  } etm_chan_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } etm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } etm_apb_rsp_t;

  typedef struct packed {
    logic ext_clk;
    logic cap_a;
    logic cap_b;
  } etm_pins_t;

endpackage

// >>> logic/etm_timer.sv
// Enhanced timer: 10-bit up/down counter, three comparators, APB slave
`timescale 1ns/1ps

// How it works
// - Ten-bit up/down counter clocked from a chosen internal or pin source.
// - Match A and B compare all bits; period compares top three bits.
// - Software cannot load the counter; software clears it only by a counter-on rising edge.
// - Outside PWM mode, overflow or selected match clears the counter and pulses the interrupt.
// - Hold bit freezes the counter; counting resumes from the held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, pin edges.
// - Counter-on low stops and keeps count; rising edge clears and starts.
// - Counter-on rising in compare mode restores both pins to initial levels.
// - Period value steps in 128 clocks; zero lets the counter overflow.
// - Channel mode: compare, capture, PWM or single pulse, timer.
// - Timer mode leaves the pin undriven; control and polarity ignored.
// - Compare match A: no change, low, high or toggle.
// - Match level equal to initial level gives no visible pin change.
// - PWM mode pin function: inactive, active, PWM, single pulse.
// - Capture mode pin function: rising, falling, both, disabled.
// - Out control: initial level in compare mode, active level in PWM.
// - Polarity bit inverts the output pin.
// - Read-only direction flag: 0 counting up, 1 counting down.
// - Clear select: match A clears, else period match or overflow.
// - Clear select ignored in PWM, single-pulse and capture modes.
// - Channel B mirrors channel A fields on comparator B and its pins.
// - PWM alignment: edge, or centre for any other code; up, down, either act alike.
module etm_timer
  import etm_pkg::*;
#(
  parameter int CNT_W = ETM_CW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_high,
  input wire logic clk_sub,
  input wire logic external_clock_pin,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  output logic output_pin_a,
  output logic output_pin_a_oe,
  output logic output_pin_b,
  output logic output_pin_b_oe,
  output logic timer_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    etm_ctrl0_t c0;
    etm_chan_t cha;
    etm_chan_t chb;
    logic [1:0] pwm_alignment;
    logic clear_select;
    logic count_direction_flag;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] match_a_value;
    logic [CNT_W-1:0] match_b_value;
    logic on_d;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_d;
    logic [1:0] hi_s1;
    logic [1:0] hi_s2;
    logic [1:0] hi_d;
    logic [5:0] div;
    logic pa;
    logic pb;
    logic pa_oe;
    logic pb_oe;
    logic pa_pin;
    logic pb_pin;
    logic [3:0] flags;
    logic irq;
    logic [31:0] rdata;
    logic ready;
  } etm_state_t;

  etm_state_t st_ff;
  etm_state_t nxt_st;

  logic [CNT_W-1:0] top;
  logic tick;
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic ovf;
  logic clr;
  logic on_rise;
  logic pwm_mode;
  logic single;
  logic cap_a_ev;
  logic cap_b_ev;
  logic rd_acc;
  logic wr_acc;

  function automatic logic cmp_pin(input logic cur, input logic [1:0] fn);
    logic r;
    r = cur;
    case (fn)
      ETM_FN_1: r = 1'b0;
      ETM_FN_2: r = 1'b1;
      ETM_FN_3: r = ~cur;
      default: r = cur;
    endcase
    return r;
  endfunction

  function automatic logic cap_edge(input logic now, input logic was,
                                    input logic [1:0] fn);
    logic r;
    r = 1'b0;
    case (fn)
      ETM_FN_0: r = now & ~was;
      ETM_FN_1: r = ~now & was;
      ETM_FN_2: r = now ^ was;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Level shown in PWM/single-pulse mode, before polarity
  function automatic logic pwm_pin(input logic [1:0] fn, input logic act,
                                   input logic oc);
    logic r;
    r = ~oc;
    case (fn)
      ETM_FN_0: r = ~oc;
      ETM_FN_1: r = oc;
      default: r = act ? oc : ~oc;
    endcase
    return r;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    // ----------------------------------------------------------------------
    // Pin synchronisers and clock-source ticks
    // ----------------------------------------------------------------------
    nxt_st.pin_s1 = {external_clock_pin, capture_input_a, capture_input_b};
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.pin_d = st_ff.pin_s2;
    nxt_st.hi_s1 = {clk_high, clk_sub};
    nxt_st.hi_s2 = st_ff.hi_s1;
    nxt_st.hi_d = st_ff.hi_s2;
    if (st_ff.hi_s2[1] & ~st_ff.hi_d[1]) begin
      nxt_st.div = st_ff.div + 6'h01;
    end
    // Divided clocks are ticks of pclk; slow clocks must be below pclk/2
    case (st_ff.c0.count_clock_select)
      ETM_CK_SYS4: tick = (st_ff.div[1:0] == 2'h3) & 1'b1;
      ETM_CK_SYS: tick = 1'b1;
      ETM_CK_H16: tick = st_ff.hi_s2[1] & ~st_ff.hi_d[1]
                         & (st_ff.div[3:0] == 4'hF);
      ETM_CK_H64: tick = st_ff.hi_s2[1] & ~st_ff.hi_d[1]
                         & (st_ff.div == 6'h3F);
      ETM_CK_SUB0, ETM_CK_SUB1: tick = st_ff.hi_s2[0] & ~st_ff.hi_d[0];
      ETM_CK_RISE: tick = st_ff.pin_s2[2] & ~st_ff.pin_d[2];
      ETM_CK_FALL: tick = ~st_ff.pin_s2[2] & st_ff.pin_d[2];
      default: tick = 1'b0;
    endcase
    // No ticks while off, paused or in the start cycle: a stale count
    // would otherwise raise matches
    tick = tick & st_ff.c0.counter_on & st_ff.on_d
         & ~st_ff.c0.counter_hold;
    // The sys/4 divider free-runs on pclk
    if (st_ff.c0.count_clock_select == ETM_CK_SYS4) begin
      nxt_st.div = st_ff.div + 6'h01;
    end

    // ----------------------------------------------------------------------
    // Comparators and clear selection
    // ----------------------------------------------------------------------
    pwm_mode = st_ff.cha.mode == ETM_MODE_PWM;
    single = pwm_mode & (st_ff.cha.pin_function == ETM_FN_3);
    top = (st_ff.c0.period_value == ETM_PER_FREE) ? ETM_CNT_MAX
        : {st_ff.c0.period_value, 7'h00};
    hit_a = tick & (st_ff.cnt == st_ff.match_a_value);
    hit_b = tick & (st_ff.cnt == st_ff.match_b_value);
    hit_p = tick & (st_ff.c0.period_value != ETM_PER_FREE)
          & (st_ff.cnt[CNT_W-1 -: 3] == st_ff.c0.period_value);
    ovf = tick & ~st_ff.count_direction_flag
        & (st_ff.cnt == ETM_CNT_MAX);
    if (pwm_mode & ~single) begin
      clr = 1'b0;
    end else if (st_ff.clear_select & ~single
                 & (st_ff.cha.mode != ETM_MODE_CAP)) begin
      clr = hit_a;
    end else if (single) begin
      clr = 1'b0;
    end else begin
      clr = hit_p | (ovf & (st_ff.c0.period_value == ETM_PER_FREE));
    end
    on_rise = st_ff.c0.counter_on & ~st_ff.on_d;
    nxt_st.on_d = st_ff.c0.counter_on;

    // ----------------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------------
    if (on_rise) begin
      nxt_st.cnt = ETM_CNT_ZERO;
      nxt_st.count_direction_flag = 1'b0;
    end else if (st_ff.c0.counter_on & ~st_ff.c0.counter_hold & tick) begin
      if (pwm_mode & ~single & (st_ff.pwm_alignment != ETM_PWM_EDGE)) begin
        // Centre aligned: triangle between zero and the period top
        if (~st_ff.count_direction_flag) begin
          if (st_ff.cnt >= top - 10'h001) begin
            nxt_st.count_direction_flag = 1'b1;
          end
          nxt_st.cnt = st_ff.cnt + 10'h001;
        end else begin
          if (st_ff.cnt <= 10'h001) begin
            nxt_st.count_direction_flag = 1'b0;
          end
          nxt_st.cnt = st_ff.cnt - 10'h001;
        end
      end else if (pwm_mode & ~single & (st_ff.cnt >= top - 10'h001)
                   & (st_ff.c0.period_value != ETM_PER_FREE)) begin
        nxt_st.cnt = ETM_CNT_ZERO;
      end else if (clr) begin
        nxt_st.cnt = ETM_CNT_ZERO;
      end else begin
        nxt_st.cnt = st_ff.cnt + 10'h001;
      end
    end

    // ----------------------------------------------------------------------
    // Capture
    // ----------------------------------------------------------------------
    cap_a_ev = (st_ff.cha.mode == ETM_MODE_CAP)
             & cap_edge(st_ff.pin_s2[1], st_ff.pin_d[1],
                        st_ff.cha.pin_function);
    cap_b_ev = (st_ff.chb.mode == ETM_MODE_CAP)
             & cap_edge(st_ff.pin_s2[0], st_ff.pin_d[0],
                        st_ff.chb.pin_function);
    if (cap_a_ev) begin
      nxt_st.match_a_value = st_ff.cnt;
    end
    if (cap_b_ev) begin
      nxt_st.match_b_value = st_ff.cnt;
    end

    // ----------------------------------------------------------------------
    // Output pins
    // ----------------------------------------------------------------------
    case (st_ff.cha.mode)
      ETM_MODE_CMP: begin
        if (on_rise) begin
          nxt_st.pa = st_ff.cha.out_control;
        end else if (hit_a & st_ff.c0.counter_on) begin
          nxt_st.pa = cmp_pin(st_ff.pa, st_ff.cha.pin_function);
        end
      end
      ETM_MODE_PWM: begin
        nxt_st.pa = pwm_pin(st_ff.cha.pin_function,
                            st_ff.c0.counter_on
                            & (st_ff.cnt < st_ff.match_a_value),
                            st_ff.cha.out_control);
      end
      default: nxt_st.pa = st_ff.pa;
    endcase
    case (st_ff.chb.mode)
      ETM_MODE_CMP: begin
        if (on_rise) begin
          nxt_st.pb = st_ff.chb.out_control;
        end else if (hit_b & st_ff.c0.counter_on) begin
          nxt_st.pb = cmp_pin(st_ff.pb, st_ff.chb.pin_function);
        end
      end
      ETM_MODE_PWM: begin
        nxt_st.pb = pwm_pin(st_ff.chb.pin_function,
                            st_ff.c0.counter_on
                            & (st_ff.cnt < st_ff.match_b_value),
                            st_ff.chb.out_control);
      end
      default: nxt_st.pb = st_ff.pb;
    endcase
    // Pin undriven in timer and capture modes
    nxt_st.pa_oe = (st_ff.cha.mode == ETM_MODE_CMP) | pwm_mode;
    nxt_st.pb_oe = (st_ff.chb.mode == ETM_MODE_CMP)
                 | (st_ff.chb.mode == ETM_MODE_PWM);

    // Single pulse ends on match A by dropping counter-on
    if (single & hit_a & st_ff.c0.counter_on) begin
      nxt_st.c0.counter_on = 1'b0;
    end
    // Pin edge starts the single pulse
    if (single & ~st_ff.c0.counter_on
        & (st_ff.pin_s2[2] & ~st_ff.pin_d[2])) begin
      nxt_st.c0.counter_on = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Event flags: A, B, P, overflow; set wins over clear
    // ----------------------------------------------------------------------
    rd_acc = psel & penable & ~pwrite & ~st_ff.ready;
    wr_acc = psel & penable & pwrite & ~st_ff.ready;
    if (wr_acc & (paddr == ETM_ADDR_FLAGS)) begin
      nxt_st.flags = st_ff.flags & ~pwdata[3:0];
    end
    nxt_st.flags = nxt_st.flags
                 | {ovf, hit_p & ~st_ff.clear_select,
                    hit_b | cap_b_ev, hit_a | cap_a_ev};
    nxt_st.irq = st_ff.c0.counter_on & (clr | hit_a | cap_a_ev);

    // ----------------------------------------------------------------------
    // APB slave: one wait state, unmapped reads zero, pslverr tied low
    // ----------------------------------------------------------------------
    nxt_st.ready = psel & penable & ~st_ff.ready;
    nxt_st.rdata = 32'h0000_0000;
    if (wr_acc) begin
      case (paddr)
        ETM_ADDR_CTRL0: nxt_st.c0 = pwdata[7:0];
        ETM_ADDR_CTRL1: begin
          nxt_st.cha = pwdata[7:2];
          nxt_st.clear_select = pwdata[0];
        end
        ETM_ADDR_CTRL2: begin
          nxt_st.chb = pwdata[7:2];
          nxt_st.pwm_alignment = pwdata[1:0];
        end
        ETM_ADDR_MAL: nxt_st.match_a_value[7:0] = pwdata[7:0];
        ETM_ADDR_MAH: nxt_st.match_a_value[9:8] = pwdata[1:0];
        ETM_ADDR_MBL: nxt_st.match_b_value[7:0] = pwdata[7:0];
        ETM_ADDR_MBH: nxt_st.match_b_value[9:8] = pwdata[1:0];
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        ETM_ADDR_CTRL0: nxt_st.rdata = {24'h0, st_ff.c0};
        ETM_ADDR_CTRL1: nxt_st.rdata = {24'h0, st_ff.cha,
                          st_ff.count_direction_flag, st_ff.clear_select};
        ETM_ADDR_CTRL2: nxt_st.rdata = {24'h0, st_ff.chb,
                                        st_ff.pwm_alignment};
        ETM_ADDR_CNTL: nxt_st.rdata = {24'h0, st_ff.cnt[7:0]};
        ETM_ADDR_CNTH: nxt_st.rdata = {30'h0, st_ff.cnt[9:8]};
        ETM_ADDR_MAL: nxt_st.rdata = {24'h0, st_ff.match_a_value[7:0]};
        ETM_ADDR_MAH: nxt_st.rdata = {30'h0, st_ff.match_a_value[9:8]};
        ETM_ADDR_MBL: nxt_st.rdata = {24'h0, st_ff.match_b_value[7:0]};
        ETM_ADDR_MBH: nxt_st.rdata = {30'h0, st_ff.match_b_value[9:8]};
        ETM_ADDR_FLAGS: nxt_st.rdata = {28'h0, st_ff.flags};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Polarity folded in here so the pins leave flip-flops
    nxt_st.pa_pin = nxt_st.pa ^ nxt_st.cha.polarity;
    nxt_st.pb_pin = nxt_st.pb ^ nxt_st.chb.polarity;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = 1'b0;
  assign output_pin_a = st_ff.pa_pin;
  assign output_pin_b = st_ff.pb_pin;
  assign output_pin_a_oe = st_ff.pa_oe;
  assign output_pin_b_oe = st_ff.pb_oe;
  assign timer_irq = st_ff.irq;

endmodule

// >>> bench/etm_timer_asserts.sv
// Port checker for the enhanced timer, bound to its top
`timescale 1ns/1ps
module etm_timer_asserts
  import etm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_pin_a,
  input wire logic output_pin_a_oe,
  input wire logic output_pin_b_oe
);
  // ----
  // Shadow of control writes
  // ----
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  logic [7:0] c2_ff;
  logic rd_done;
  assign rd_done = psel && penable && pready && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_ff <= 8'h00;
      c1_ff <= 8'h00;
      c2_ff <= 8'h00;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == ETM_ADDR_CTRL0) c0_ff <= pwdata[7:0];
      if (paddr == ETM_ADDR_CTRL1) c1_ff <= pwdata[7:0];
      if (paddr == ETM_ADDR_CTRL2) c2_ff <= pwdata[7:0];
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_tmr_a; (c1_ff[7:6] == ETM_MODE_TMR) [*3]; endsequence
  sequence s_cmp_b; (c2_ff[7:6] == ETM_MODE_CMP) [*3]; endsequence
  sequence s_start; $rose(c0_ff[3]) && c1_ff[7:6] == ETM_MODE_CMP; endsequence
  property p_wait; s_wait |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_cause; pready |-> $past(psel && penable); endproperty
  property p_noerr; pslverr == 1'b0; endproperty
  property p_cnth;
    rd_done && paddr == ETM_ADDR_CNTH |-> prdata[31:2] == 30'h0;
  endproperty
  property p_unmap; rd_done && paddr > ETM_ADDR_FLAGS |-> prdata == 32'h0;
  endproperty
  property p_c2rd;
    rd_done && paddr == ETM_ADDR_CTRL2 |-> prdata == {24'h0, c2_ff};
  endproperty
  property p_tmr; s_tmr_a |-> !output_pin_a_oe; endproperty
  property p_cmp; s_cmp_b |-> output_pin_b_oe; endproperty
  // Pin reload is registered, so allow a short settling span
  property p_start;
    s_start |-> ##[1:3] output_pin_a == (c1_ff[3] ^ c1_ff[2]);
  endproperty
  a_wait: assert property (p_wait) else $error("no ready after wait");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_cause: assert property (p_cause) else $error("ready without access");
  a_noerr: assert property (p_noerr) else $error("slave error raised");
  a_cnth: assert property (p_cnth) else $error("count high too wide");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_c2rd: assert property (p_c2rd) else $error("ctrl2 readback");
  a_tmr: assert property (p_tmr) else $error("pin driven in timer");
  a_cmp: assert property (p_cmp) else $error("pin b not driven");
  a_start: assert property (p_start) else $error("no initial level");
endmodule
bind etm_timer etm_timer_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_pin_a,
  .output_pin_a_oe, .output_pin_b_oe);

// >>> bench/etm_pins_model.sv
// Far-side pin model: external count clock and capture inputs
`timescale 1ns/1ps
module etm_pins_model
  import etm_pkg::*;
(
  input wire logic pclk,
  output etm_pins_t pins
);
  initial pins = '0;
  // Levels last 4 cycles so the 2-FF syncs never miss an edge
  task automatic clk_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      pins.ext_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      pins.ext_clk <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask
  task automatic cap_pulse();
    repeat (4) @(posedge pclk);
    pins.cap_a <= 1'b1;
    pins.cap_b <= 1'b1;
    repeat (8) @(posedge pclk);
    pins.cap_a <= 1'b0;
    pins.cap_b <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// >>> bench/etm_timer_bench.sv
// Self-checking bench for the enhanced timer
`timescale 1ns/1ps
module etm_timer_bench
  import etm_pkg::*;
;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
  } etm_note_t;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_high = 1'b0;
  logic clk_sub = 1'b0;
  etm_apb_req_t req = '0;
  etm_apb_rsp_t rsp;
  etm_pins_t pins;
  logic pa, pa_oe, pb, pb_oe;
  logic irq;
  int irq_n = 0;
  etm_note_t notes[$];
  int err_total = 0;
  int compares = 0;
  logic [31:0] seed = 32'h00014C9B;
  always #2 pclk = ~pclk;
  always #16 clk_high = ~clk_high;
  always #500 clk_sub = ~clk_sub;
  etm_timer uut (.pclk(pclk), .presetn(presetn), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
    .pwdata(req.pwdata), .prdata(rsp.prdata), .pready(rsp.pready),
    .pslverr(rsp.pslverr), .clk_high(clk_high), .clk_sub(clk_sub),
    .external_clock_pin(pins.ext_clk), .capture_input_a(pins.cap_a),
    .capture_input_b(pins.cap_b), .output_pin_a(pa),
    .output_pin_a_oe(pa_oe), .output_pin_b(pb), .output_pin_b_oe(pb_oe),
    .timer_irq(irq));
  etm_pins_model model (.pclk(pclk), .pins(pins));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic lvl(logic [1:0] m, logic [1:0] f, logic oc);
    if (m == ETM_MODE_PWM) return f[0] ? oc : ~oc;
    case (f)
      ETM_FN_1: return 1'b0;
      ETM_FN_2: return 1'b1;
      ETM_FN_3: return ~oc;
      default: return oc;
    endcase
  endfunction
  task automatic flag(input string s);
    err_total++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= w ? d : 32'h0;
    if (!w) notes.push_back('{d, m});
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    apb(1'b0, a, e, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic cmp_rd(input etm_note_t e);
    compares++;
    if (((rsp.prdata ^ e.val) & e.msk) !== 32'h0) flag("read data");
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) flag("pin level");
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      if (notes.size() == 0) flag("read without note");
      else cmp_rd(notes.pop_front());
    end
  end
  always @(posedge pclk) begin
    if (irq === 1'b1) irq_n++;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    flag("watchdog expired");
    complete_run();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    logic [31:0] d;
    logic [1:0] md;
    logic [1:0] fn;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i <= 9; i++) rd(8'(i * 4), 32'h0, ALL);
    wr(8'h40, rnd());
    rd(8'h40, 32'h0, ALL);
    wr(ETM_ADDR_CNTL, 32'hFF);
    rd(ETM_ADDR_CNTL, 32'h0, ALL);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(ETM_ADDR_MAL + 8'(i * 4), d);
      rd(ETM_ADDR_MAL + 8'(i * 4), d & (i[0] ? 32'h3 : 32'hFF), ALL);
    end
    d = rnd() & 32'hFC;
    wr(ETM_ADDR_CTRL2, d);
    rd(ETM_ADDR_CTRL2, d, ALL);
    d = rnd() & 32'hFD;
    wr(ETM_ADDR_CTRL1, d);
    rd(ETM_ADDR_CTRL1, d, ALL);
    wr(ETM_ADDR_CTRL1, 32'hC0);
    wr(ETM_ADDR_CTRL2, 32'hC0);
    wr(ETM_ADDR_CTRL0, 32'h98);
    rd(ETM_ADDR_CNTL, 32'h0, ALL);
    rd(ETM_ADDR_CNTH, 32'h0, ALL);
    cyc(1);
    cmp_pin(pa_oe, 1'b0);
    cmp_pin(pb_oe, 1'b0);
    wr(ETM_ADDR_CTRL0, 32'h18);
    cyc(300);
    wr(ETM_ADDR_CTRL0, 32'h98);
    rd(ETM_ADDR_CNTH, 32'h1, ALL);
    wr(ETM_ADDR_CTRL0, 32'h10);
    cyc(50);
    rd(ETM_ADDR_CNTH, 32'h1, ALL);
    wr(ETM_ADDR_CTRL0, 32'h19);
    cyc(300);
    wr(ETM_ADDR_CTRL0, 32'h99);
    rd(ETM_ADDR_CNTH, 32'h0, ALL);
    rd(ETM_ADDR_CNTL, 32'h0, 32'h80);
    wr(ETM_ADDR_CTRL0, 32'h10);
    irq_n = 0;
    wr(ETM_ADDR_MAL, 32'h32);
    wr(ETM_ADDR_MAH, 32'h0);
    wr(ETM_ADDR_CTRL1, 32'hC1);
    wr(ETM_ADDR_CTRL0, 32'h18);
    cyc(300);
    wr(ETM_ADDR_CTRL0, 32'h98);
    rd(ETM_ADDR_CNTL, 32'h0, 32'hC0);
    cmp_pin(irq_n > 0, 1'b1);
    wr(ETM_ADDR_CTRL1, 32'hC0);
    wr(ETM_ADDR_CTRL0, 32'h60);
    wr(ETM_ADDR_CTRL0, 32'h68);
    model.clk_pulses(5);
    rd(ETM_ADDR_CNTL, 32'h5, ALL);
    wr(ETM_ADDR_CTRL0, 32'h70);
    wr(ETM_ADDR_CTRL0, 32'h78);
    model.clk_pulses(3);
    rd(ETM_ADDR_CNTL, 32'h3, ALL);
    for (int f = 0; f < 4; f++) begin
      wr(ETM_ADDR_CTRL0, 32'h10);
      for (int i = 0; i < 4; i++) wr(ETM_ADDR_MAL + 8'(i * 4), 32'h55);
      wr(ETM_ADDR_CTRL1, 32'h40 | (32'(f) << 4));
      wr(ETM_ADDR_CTRL2, 32'h40 | (32'(f) << 4));
      wr(ETM_ADDR_CTRL0, 32'h98);
      model.cap_pulse();
      rd(ETM_ADDR_MAL, f == 3 ? 32'h55 : 32'h0, ALL);
      rd(ETM_ADDR_MBL, f == 3 ? 32'h55 : 32'h0, ALL);
    end
    wr(ETM_ADDR_MAL, 32'h14);
    wr(ETM_ADDR_MAH, 32'h0);
    wr(ETM_ADDR_MBL, 32'h1E);
    wr(ETM_ADDR_MBH, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      md = i < 4 ? ETM_MODE_CMP : ETM_MODE_PWM;
      fn = 2'(i % 4);
      wr(ETM_ADDR_CTRL0, 32'h10);
      wr(ETM_ADDR_CTRL1, {24'h0, md, fn, d[0], d[1], 2'b00});
      wr(ETM_ADDR_CTRL2, {24'h0, md, fn, d[2], d[3], 2'b00});
      wr(ETM_ADDR_CTRL0, 32'h18);
      cyc(3);
      if (i < 4) cmp_pin(pa, d[0] ^ d[1]);
      if (i < 4) cmp_pin(pb, d[2] ^ d[3]);
      cyc(60);
      cmp_pin(pa, lvl(md, fn, d[0]) ^ d[1]);
      cmp_pin(pb, lvl(md, fn, d[2]) ^ d[3]);
      cmp_pin(pa_oe, 1'b1);
    end
    // System clock / 4: about 101 ticks in 404 cycles
    wr(ETM_ADDR_CTRL0, 32'h10);
    wr(ETM_ADDR_CTRL1, 32'hC0);
    wr(ETM_ADDR_CTRL0, 32'h08);
    cyc(400);
    wr(ETM_ADDR_CTRL0, 32'h88);
    rd(ETM_ADDR_CNTL, 32'h40, 32'hC0);
    // Centre aligned, period 128: counting down after tick 128
    wr(ETM_ADDR_CTRL0, 32'h10);
    wr(ETM_ADDR_CTRL1, 32'hA0);
    wr(ETM_ADDR_CTRL2, 32'h01);
    wr(ETM_ADDR_CTRL0, 32'h19);
    cyc(150);
    rd(ETM_ADDR_CTRL1, 32'hA2, ALL);
    complete_run();
  end
endmodule
